// ### cmr_host.sv
// host bus model: 8-bit processor driving the register bank strobes
`timescale 1ns/100ps
module cmr_host (
	input wire logic clk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [15:0] addr,
	output logic [7:0] data_in
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 16'h0000;
		data_in = 8'h00;
	end

	// ----------------------------------------------------------------
	// one access
	// ----------------------------------------------------------------
	// pins are synced inside, so address settles 3 cycles before strobe
	task automatic access(input logic [15:0] a, input logic [7:0] d,
		input logic rd, output logic [7:0] q, output logic oe);
		@(negedge clk);
		addr = a;
		data_in = d;
		cs_n = 1'b0;
		repeat (3) @(negedge clk);
		rd_n = !rd;
		wr_n = rd;
		repeat (5) @(negedge clk);
		q = data_out;
		oe = data_oe;
		rd_n = 1'b1;
		wr_n = 1'b1;
		@(negedge clk);
		cs_n = 1'b1;
		// released lines must not look like the last value
		addr = ~addr;
		data_in = ~data_in;
		repeat (4) @(negedge clk);
	endtask
endmodule

// ### cmr_pkg.sv
// constants, types and register map of the channel interrupt/mode register bank
package cmr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_TOPO = 16'h0100;
	localparam logic [15:0] ADDR_CTRL = 16'h0103;
	localparam logic [15:0] ADDR_IND_PATH = 16'h0120;
	localparam logic [15:0] ADDR_IND_TXCELL = 16'h0127;
	localparam logic [15:0] ADDR_IND_RXCELL = 16'h0128;
	localparam logic [15:0] ADDR_IND_RXPKT = 16'h012a;
	// low twelve bits of channel-indexed source status bytes
	localparam logic [11:0] OFS_PATH_B2 = 12'h189;
	localparam logic [11:0] OFS_PATH_B1 = 12'h18a;
	localparam logic [11:0] OFS_PATH_B0 = 12'h18b;
	localparam logic [11:0] OFS_CELL_B1 = 12'h70a;
	localparam logic [11:0] OFS_CELL_B0 = 12'h70b;
	localparam logic [11:0] OFS_TXCELL = 12'hf0b;
	// source enable byte sits this far below its status byte
	localparam logic [15:0] OFS_ENABLE_GAP = 16'h0004;
	// channel digit in the top nibble
	localparam logic [3:0] CH_FIRST = 4'h1;
	localparam logic [3:0] CH_LAST = 4'h3;

	// ----------------------------------------------------------------
	// source status slots
	// ----------------------------------------------------------------
	localparam int NUM_CH = 3;
	localparam int NUM_SLOTS = 24;
	localparam logic [4:0] SLOTS_PER_CH = 5'd7;
	localparam logic [4:0] SLOT_PATH_B2 = 5'd0;
	localparam logic [4:0] SLOT_PATH_B1 = 5'd1;
	localparam logic [4:0] SLOT_PATH_B0 = 5'd2;
	localparam logic [4:0] SLOT_CELL_B1 = 5'd3;
	localparam logic [4:0] SLOT_CELL_B0 = 5'd4;
	localparam logic [4:0] SLOT_PKT = 5'd5;
	localparam logic [4:0] SLOT_TXCELL = 5'd6;
	localparam logic [4:0] SLOT_CONCAT_B2 = 5'd21;
	localparam logic [4:0] SLOT_CONCAT_B1 = 5'd22;
	localparam logic [4:0] SLOT_CONCAT_B0 = 5'd23;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TOPO_SEL_LSB = 0;
	localparam int TOPO_SPLIT_BIT = 3;
	localparam int TOPO_VARIANT_LSB = 4;
	localparam int CTRL_SOFT_RESET_BIT = 0;
	localparam int CTRL_PROTO_BIT = 2;
	localparam int CTRL_RX_PLL_OFF_BIT = 6;
	localparam int CTRL_TX_PLL_OFF_BIT = 7;
	localparam int IND_CONCAT_BIT = 4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] RST_TOPO_SEL = 2'h0;
	localparam logic [3:0] RST_VARIANT = 4'h0;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;

	typedef enum logic [1:0] {
		TOPO_CONCAT = 2'b00,
		TOPO_CONCAT_ALT = 2'b01,
		TOPO_DS3_STS3 = 2'b10,
		TOPO_STS1_STS3 = 2'b11
	} cmr_topo_e;

	typedef enum logic {
		PROTO_CELL = 1'b0,
		PROTO_PACKET = 1'b1
	} cmr_proto_e;

	typedef struct packed {
		logic [7:0] stat;
	} cmr_byte_s;

endpackage

// ### cmr_regbank.sv
// channel interrupt indicators, source status and mode control registers
// Functional notes
// - read-only path indicator at 0x0120, resets zero
// - indicator bit reads one while channel requests
// - cell, packet, transmit indicators share layout
// - top address nibble 1-3 selects channel N-1
// - path status bytes 2,1,0 per channel
// - concat path status bytes 2,1,0 fixed
// - receive cell status bytes 1 then 0
// - packet status aliases cell byte 0 address
// - transmit cell status one byte per channel
// - three topology modes supported
// - concat mode keeps two extra tributaries reachable
// - all active channels addressable from host side
// - topology byte fields, bit 2 reads zero
// - control byte 0 fields, unused read zero
// - protocol bit zero cell, one packet
// - status read clears bits, interrupt negates
`timescale 1ns/100ps
module cmr_regbank (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CS_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	input wire logic [71:0] RX_PATH_EVT,
	input wire logic [23:0] CONCAT_PATH_EVT,
	input wire logic [47:0] RX_CELL_EVT,
	input wire logic [23:0] RX_PKT_EVT,
	input wire logic [23:0] TX_CELL_EVT,
	output logic [1:0] TOPOLOGY_SELECT,
	output logic SPLIT_BUS_SELECT,
	output logic [3:0] CHANNEL_VARIANT_SELECT,
	output logic FRAMING_PROTOCOL_SELECT,
	output logic TX_PLL_OFF,
	output logic RX_PLL_OFF,
	output logic SOFT_RESET,
	output logic INT_N
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr1;
		logic [15:0] addr2;
		logic [7:0] wd1;
		logic [7:0] wd2;
		logic cs_n1;
		logic cs_n2;
		logic rd_n1;
		logic rd_n2;
		logic wr_n1;
		logic wr_n2;
		logic rd_last;
		logic wr_last;
		logic [1:0] topo;
		logic split_bus;
		logic [3:0] variant;
		logic tx_pll_off;
		logic rx_pll_off;
		logic proto;
		logic soft_rst;
		logic [23:0][7:0] en;
		logic [7:0] rdata;
		logic oe;
		logic int_n;
	} cmr_state_s;

	localparam cmr_state_s RST_STATE = '{
		addr1: 16'h0000, addr2: 16'h0000, wd1: 8'h00, wd2: 8'h00,
		cs_n1: 1'b1, cs_n2: 1'b1, rd_n1: 1'b1, rd_n2: 1'b1,
		wr_n1: 1'b1, wr_n2: 1'b1, rd_last: 1'b1, wr_last: 1'b1,
		topo: cmr_pkg::RST_TOPO_SEL, split_bus: 1'b0,
		variant: cmr_pkg::RST_VARIANT, tx_pll_off: 1'b0,
		rx_pll_off: 1'b0, proto: 1'b0, soft_rst: 1'b0,
		en: {24{cmr_pkg::RST_ENABLE}}, rdata: 8'h00, oe: 1'b0,
		int_n: 1'b1};

	cmr_state_s q;
	cmr_state_s next_q;

	logic [23:0][7:0] stat;
	logic [23:0][7:0] set_vec;
	logic [23:0] clr_vec;
	logic [2:0] ind_path;
	logic ind_concat;
	logic [2:0] ind_rxcell;
	logic [2:0] ind_rxpkt;
	logic [2:0] ind_txcell;
	logic rd_go;
	logic wr_go;
	logic concat_mode;
	logic [5:0] stat_hit;
	logic [5:0] en_hit;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// returns {hit, slot}; top nibble picks channel N-1
	function automatic logic [5:0] slot_decode(input logic [15:0] a,
			input logic proto, input logic concat);
		logic [4:0] base;
		logic first;
		logic [5:0] r;
		base = 5'(5'(a[15:12] - cmr_pkg::CH_FIRST) * cmr_pkg::SLOTS_PER_CH);
		first = (a[15:12] == cmr_pkg::CH_FIRST);
		r = 6'h00;
		if (a[15:12] inside {[cmr_pkg::CH_FIRST:cmr_pkg::CH_LAST]}) begin
			case (a[11:0])
			// concat bytes take channel 0's path addresses in concat mode, using slots 21-23
			cmr_pkg::OFS_PATH_B2: r = (concat && first) ?
					{1'b1, cmr_pkg::SLOT_CONCAT_B2} :
					{1'b1, 5'(base + cmr_pkg::SLOT_PATH_B2)};
			cmr_pkg::OFS_PATH_B1: r = (concat && first) ?
					{1'b1, cmr_pkg::SLOT_CONCAT_B1} :
					{1'b1, 5'(base + cmr_pkg::SLOT_PATH_B1)};
			cmr_pkg::OFS_PATH_B0: r = (concat && first) ?
					{1'b1, cmr_pkg::SLOT_CONCAT_B0} :
					{1'b1, 5'(base + cmr_pkg::SLOT_PATH_B0)};
			cmr_pkg::OFS_CELL_B1: r = {1'b1, 5'(base + cmr_pkg::SLOT_CELL_B1)};
			cmr_pkg::OFS_CELL_B0: r = proto ?
					{1'b1, 5'(base + cmr_pkg::SLOT_PKT)} :
					{1'b1, 5'(base + cmr_pkg::SLOT_CELL_B0)};
			cmr_pkg::OFS_TXCELL: r = {1'b1, 5'(base + cmr_pkg::SLOT_TXCELL)};
			default: r = 6'h00;
			endcase
		end
		return r;
	endfunction

	assign concat_mode = (q.topo == cmr_pkg::TOPO_CONCAT) ||
			(q.topo == cmr_pkg::TOPO_CONCAT_ALT);
	assign stat_hit = slot_decode(q.addr2, q.proto, concat_mode);
	assign en_hit = slot_decode(16'(q.addr2 + cmr_pkg::OFS_ENABLE_GAP),
			q.proto, concat_mode);
	// strobes act once on their synchronised falling edge
	assign rd_go = q.rd_last && !q.rd_n2 && !q.cs_n2;
	assign wr_go = q.wr_last && !q.wr_n2 && !q.cs_n2;

	// ----------------------------------------------------------------
	// source status bytes
	// ----------------------------------------------------------------
	// every channel's slots stay live in all topologies
	always_comb begin
		set_vec = '0;
		for (int c = 0; c < cmr_pkg::NUM_CH; c++) begin
			set_vec[c*7+0] = RX_PATH_EVT[c*24+16 +: 8];
			set_vec[c*7+1] = RX_PATH_EVT[c*24+8 +: 8];
			set_vec[c*7+2] = RX_PATH_EVT[c*24 +: 8];
			set_vec[c*7+3] = RX_CELL_EVT[c*16+8 +: 8];
			set_vec[c*7+4] = RX_CELL_EVT[c*16 +: 8];
			set_vec[c*7+5] = RX_PKT_EVT[c*8 +: 8];
			set_vec[c*7+6] = TX_CELL_EVT[c*8 +: 8];
		end
		set_vec[21] = CONCAT_PATH_EVT[23:16];
		set_vec[22] = CONCAT_PATH_EVT[15:8];
		set_vec[23] = CONCAT_PATH_EVT[7:0];
	end

	always_comb begin
		for (int i = 0; i < cmr_pkg::NUM_SLOTS; i++) begin
			clr_vec[i] = rd_go && stat_hit[5] && (stat_hit[4:0] == 5'(i));
		end
	end

	for (genvar i = 0; i < cmr_pkg::NUM_SLOTS; i++) begin : g_stat
		cmr_stat_byte u_stat (
			.clk(REF_CLK),
			.rst_n(RESETN),
			.set(set_vec[i]),
			.clear(clr_vec[i]),
			.flush(q.soft_rst),
			.stat(stat[i])
		);
	end

	// ----------------------------------------------------------------
	// channel indicators
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < cmr_pkg::NUM_CH; c++) begin
			ind_path[c] = |((stat[c*7+0] & q.en[c*7+0]) |
					(stat[c*7+1] & q.en[c*7+1]) |
					(stat[c*7+2] & q.en[c*7+2]));
			ind_rxcell[c] = |((stat[c*7+3] & q.en[c*7+3]) |
					(stat[c*7+4] & q.en[c*7+4]));
			ind_rxpkt[c] = |(stat[c*7+5] & q.en[c*7+5]);
			ind_txcell[c] = |(stat[c*7+6] & q.en[c*7+6]);
		end
		ind_concat = |((stat[21] & q.en[21]) | (stat[22] & q.en[22]) |
				(stat[23] & q.en[23]));
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.addr1 = ADDR;
		next_q.addr2 = q.addr1;
		next_q.wd1 = DATA_IN;
		next_q.wd2 = q.wd1;
		next_q.cs_n1 = CS_N;
		next_q.cs_n2 = q.cs_n1;
		next_q.rd_n1 = RD_N;
		next_q.rd_n2 = q.rd_n1;
		next_q.wr_n1 = WR_N;
		next_q.wr_n2 = q.wr_n1;
		next_q.rd_last = q.rd_n2;
		next_q.wr_last = q.wr_n2;
		next_q.oe = !q.cs_n2 && !q.rd_n2;
		next_q.soft_rst = 1'b0;
		if (rd_go) begin
			case (q.addr2)
			cmr_pkg::ADDR_TOPO: next_q.rdata = {q.variant, q.split_bus,
					1'b0, q.topo};
			cmr_pkg::ADDR_CTRL: next_q.rdata = {q.tx_pll_off,
					q.rx_pll_off, 3'b000, q.proto, 1'b0, 1'b0};
			cmr_pkg::ADDR_IND_PATH: next_q.rdata = {3'b000, ind_concat,
					1'b0, ind_path};
			cmr_pkg::ADDR_IND_RXCELL: next_q.rdata = {5'b00000, ind_rxcell};
			cmr_pkg::ADDR_IND_RXPKT: next_q.rdata = {5'b00000, ind_rxpkt};
			cmr_pkg::ADDR_IND_TXCELL: next_q.rdata = {5'b00000, ind_txcell};
			default: next_q.rdata = stat_hit[5] ? stat[stat_hit[4:0]] :
					(en_hit[5] ? q.en[en_hit[4:0]] : 8'h00);
			endcase
		end
		if (wr_go) begin
			case (q.addr2)
			cmr_pkg::ADDR_TOPO: begin
				next_q.topo = q.wd2[cmr_pkg::TOPO_SEL_LSB +: 2];
				next_q.split_bus = q.wd2[cmr_pkg::TOPO_SPLIT_BIT];
				next_q.variant = q.wd2[cmr_pkg::TOPO_VARIANT_LSB +: 4];
			end
			cmr_pkg::ADDR_CTRL: begin
				next_q.tx_pll_off = q.wd2[cmr_pkg::CTRL_TX_PLL_OFF_BIT];
				next_q.rx_pll_off = q.wd2[cmr_pkg::CTRL_RX_PLL_OFF_BIT];
				next_q.proto = q.wd2[cmr_pkg::CTRL_PROTO_BIT];
				// self-clearing: a one pulse, never a stuck reset
				next_q.soft_rst = q.wd2[cmr_pkg::CTRL_SOFT_RESET_BIT];
			end
			default: begin
				if (en_hit[5]) begin
					next_q.en[en_hit[4:0]] = q.wd2;
				end
			end
			endcase
		end
		// status bytes lag one cycle, so negation follows the read by two
		next_q.int_n = !(|{ind_path, ind_concat, ind_rxcell, ind_rxpkt,
				ind_txcell});
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			q <= RST_STATE;
		end else begin
			q <= next_q;
		end
	end

	assign DATA_OUT = q.rdata;
	assign DATA_OE = q.oe;
	assign TOPOLOGY_SELECT = q.topo;
	assign SPLIT_BUS_SELECT = q.split_bus;
	assign CHANNEL_VARIANT_SELECT = q.variant;
	assign FRAMING_PROTOCOL_SELECT = q.proto;
	assign TX_PLL_OFF = q.tx_pll_off;
	assign RX_PLL_OFF = q.rx_pll_off;
	assign SOFT_RESET = q.soft_rst;
	assign INT_N = q.int_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking chk_clk @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);
	sequence s_read(logic [15:0] a);
		rd_go && (q.addr2 == a);
	endsequence

	sequence s_write(logic [15:0] a);
		wr_go && (q.addr2 == a);
	endsequence

	a_ind_path_read: assert property (
		s_read(cmr_pkg::ADDR_IND_PATH) |=>
			(DATA_OUT[2:0] == $past(ind_path)) &&
			(DATA_OUT[4] == $past(ind_concat)))
		else $error("path indicator read does not match channel state");
	a_ind_unused_zero: assert property (
		s_read(cmr_pkg::ADDR_IND_PATH) |=>
			(DATA_OUT[7:5] == 3'b000) && !DATA_OUT[3])
		else $error("unused indicator bits read nonzero");
	a_int_follows_ind: assert property (
		(|{ind_path, ind_concat, ind_rxcell, ind_rxpkt, ind_txcell})
			|=> !INT_N)
		else $error("interrupt not asserted for a pending channel");
	a_int_negate: assert property (
		!(|{ind_path, ind_concat, ind_rxcell, ind_rxpkt, ind_txcell})
			|=> INT_N)
		else $error("interrupt held with no source pending");
	a_read_clears: assert property (
		(rd_go && stat_hit[5] && (set_vec[stat_hit[4:0]] == 8'h00))
			|=> (stat[$past(stat_hit[4:0])] == 8'h00))
		else $error("source status not cleared by its read");
	a_topo_bit2_zero: assert property (
		s_read(cmr_pkg::ADDR_TOPO) |=> !DATA_OUT[2])
		else $error("topology byte bit 2 reads one");
	a_ctrl_unused_zero: assert property (
		s_read(cmr_pkg::ADDR_CTRL) |=>
			(DATA_OUT[5:3] == 3'b000) && (DATA_OUT[1:0] == 2'b00))
		else $error("control byte 0 unused bits read nonzero");
	a_proto_write: assert property (
		s_write(cmr_pkg::ADDR_CTRL) |=>
			(FRAMING_PROTOCOL_SELECT == $past(q.wd2[2])))
		else $error("framing protocol bit not taken from write");
	a_soft_pulse: assert property (
		(s_write(cmr_pkg::ADDR_CTRL) ##0 q.wd2[0]) |=>
			SOFT_RESET ##1 (!SOFT_RESET && (stat == $past(set_vec))))
		else $error("soft reset pulse or flush wrong");
	a_chan_range: assert property (
		(q.addr2[15:12] == 4'h0 || q.addr2[15:12] > 4'h3) |-> !stat_hit[5])
		else $error("status decoded outside channel digits 1 to 3");
	a_pkt_alias: assert property (
		(q.addr2 == 16'h270b && q.proto) |-> (stat_hit == {1'b1, 5'd12}))
		else $error("packet status not aliased on cell byte 0");
endmodule

// ### cmr_stat_byte.sv
// one sticky source status byte with clear-on-read
`timescale 1ns/100ps
module cmr_stat_byte (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] set,
	input wire logic clear,
	input wire logic flush,
	output logic [7:0] stat
);

	cmr_pkg::cmr_byte_s q;
	cmr_pkg::cmr_byte_s next_q;

	// a source firing in the clearing cycle survives the clear
	always_comb begin
		next_q = q;
		if (clear || flush) begin
			next_q.stat = cmr_pkg::RST_STATUS;
		end
		next_q.stat = next_q.stat | set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign stat = q.stat;

	a_set_beats_clear: assert property (
		@(posedge clk) disable iff (!rst_n)
		(clear && (set != 8'h00)) |=> ((stat & $past(set)) == $past(set)))
		else $error("event lost while its status byte was cleared");

endmodule

// ### tb_channel_irq_and_mode_config.sv
// self-checking bench for the channel interrupt and mode register bank
`timescale 1ns/100ps
module tb_channel_irq_and_mode_config;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0] d;
		logic [7:0] q;
	} cmr_row_s;

	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [15:0] addr;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe;
	logic [71:0] rx_path_evt = '0;
	logic [23:0] concat_evt = '0;
	logic [47:0] rx_cell_evt = '0;
	logic [23:0] rx_pkt_evt = '0;
	logic [23:0] tx_cell_evt = '0;
	logic [1:0] topo_sel;
	logic split_bus;
	logic [3:0] variant;
	logic proto;
	logic tx_pll_off;
	logic rx_pll_off;
	logic soft_reset;
	logic int_n;
	logic [7:0] soft_cnt = 8'h00;
	int n_checks = 0;
	int miscompares = 0;
	logic [11:0] ofs [8] = '{12'h189, 12'h18a, 12'h18b, 12'h70a,
		12'h70b, 12'h70b, 12'hf0b, 12'h189};
	logic [15:0] ind [8] = '{16'h0120, 16'h0120, 16'h0120, 16'h0128,
		16'h0128, 16'h012a, 16'h0127, 16'h0120};
	cmr_row_s rows [7] = '{
		'{16'h0100, 8'hff, 8'hfb},
		'{16'h0100, 8'h5a, 8'h5a},
		'{16'h0103, 8'hc6, 8'hc4},
		'{16'h0120, 8'hff, 8'h00},
		'{16'h0128, 8'hff, 8'h00},
		'{16'h0200, 8'hff, 8'h00},
		'{16'h2186, 8'h3c, 8'h3c}};

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (soft_reset === 1'b1) begin
			soft_cnt <= soft_cnt + 8'h01;
		end
	end

	cmr_host host (.clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in));

	cmr_regbank uut (.REF_CLK(ref_clk), .RESETN(resetn), .CS_N(cs_n),
		.RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .DATA_IN(data_in),
		.DATA_OUT(data_out), .DATA_OE(data_oe), .RX_PATH_EVT(rx_path_evt),
		.CONCAT_PATH_EVT(concat_evt), .RX_CELL_EVT(rx_cell_evt),
		.RX_PKT_EVT(rx_pkt_evt), .TX_CELL_EVT(tx_cell_evt),
		.TOPOLOGY_SELECT(topo_sel), .SPLIT_BUS_SELECT(split_bus),
		.CHANNEL_VARIANT_SELECT(variant),
		.FRAMING_PROTOCOL_SELECT(proto), .TX_PLL_OFF(tx_pll_off),
		.RX_PLL_OFF(rx_pll_off), .SOFT_RESET(soft_reset), .INT_N(int_n));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic oe;
		host.access(a, d, 1'b0, q, oe);
	endtask

	task automatic rd_chk(input string what, input logic [15:0] a,
		input logic [7:0] exp);
		logic [7:0] q;
		logic oe;
		host.access(a, 8'h00, 1'b1, q, oe);
		check("read enable", 8'h01, {7'h00, oe});
		check(what, exp, q);
	endtask

	task automatic wait_int(input logic exp, input int bound);
		int i;
		i = 0;
		while (int_n !== exp && i < bound) begin
			@(negedge ref_clk);
			i++;
		end
		check("interrupt output", {7'h00, exp}, {7'h00, int_n});
	endtask

	task automatic pulse(input int k, input int c, input logic [7:0] v);
		@(negedge ref_clk);
		case (k)
			0, 1, 2: rx_path_evt[c * 24 + (2 - k) * 8 +: 8] = v;
			3, 4: rx_cell_evt[c * 16 + (4 - k) * 8 +: 8] = v;
			5: rx_pkt_evt[c * 8 +: 8] = v;
			6: tx_cell_evt[c * 8 +: 8] = v;
			default: concat_evt[(2 - c) * 8 +: 8] = v;
		endcase
		@(negedge ref_clk);
		rx_path_evt = '0;
		rx_cell_evt = '0;
		rx_pkt_evt = '0;
		tx_cell_evt = '0;
		concat_evt = '0;
	endtask

	// one source byte: masked event, enabled event, service, clear
	task automatic src_case(input int k, input int c);
		logic [15:0] sa;
		logic [7:0] ib;
		sa = {4'(c + 1), ofs[k]};
		ib = 8'h01 << c;
		if (k == 7) begin
			sa = {4'h1, ofs[k]} + 16'(c);
			ib = 8'h10;
		end
		// both concat encodings get used across the concat channels
		wr(16'h0100, k == 7 ? {7'h00, c[0]} : 8'h02);
		wr(16'h0103, k == 5 ? 8'h04 : 8'h00);
		wr(sa - cmr_pkg::OFS_ENABLE_GAP, 8'h80);
		pulse(k, c, 8'h41);
		repeat (4) @(negedge ref_clk);
		check("masked interrupt", 8'h01, {7'h00, int_n});
		pulse(k, c, 8'h80);
		wait_int(1'b0, 4);
		rd_chk("indicator", ind[k], ib);
		rd_chk("source status", sa, 8'hc1);
		rd_chk("status after read", sa, 8'h00);
		wait_int(1'b1, 4);
		wr(sa - cmr_pkg::OFS_ENABLE_GAP, 8'h00);
	endtask

	task automatic print_verdict();
		$display("checks %0d, miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1'b1;
		check("idle interrupt", 8'h01, {7'h00, int_n});
		rd_chk("topology reset", 16'h0100, 8'h00);
		rd_chk("control reset", 16'h0103, 8'h00);
		rd_chk("indicator reset", 16'h0120, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd_chk("register readback", rows[i].a, rows[i].q);
		end
		check("topology outputs", 8'h5a, {variant, split_bus, 1'b0,
			topo_sel});
		check("control outputs", 8'h07, {5'h00, tx_pll_off, rx_pll_off,
			proto});
		wr(16'h2186, 8'h00);
		for (int k = 0; k < 8; k++) begin
			for (int c = 0; c < 3; c++) begin
				src_case(k, c);
			end
		end
		// soft reset drops pending status but keeps the bus usable
		wr(16'h1187, 8'h01);
		pulse(7, 2, 8'h01);
		wait_int(1'b0, 4);
		wr(16'h0103, 8'h01);
		check("soft reset pulses", 8'h01, soft_cnt);
		wait_int(1'b1, 4);
		rd_chk("status after soft reset", 16'h118b, 8'h00);
		rd_chk("enable kept", 16'h1187, 8'h01);
		// an event on the clearing edge must outlive the read
		fork
			rd_chk("status on clear edge", 16'h118b, 8'h00);
			begin
				repeat (5) @(negedge ref_clk);
				pulse(7, 2, 8'h02);
			end
		join
		rd_chk("event kept over clear", 16'h118b, 8'h02);
		wr(16'h0100, 8'hf3);
		wr(16'h0103, 8'hc4);
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("outputs in reset", 8'h01, {topo_sel, split_bus, variant,
			int_n});
		check("control in reset", 8'h00, {5'h00, tx_pll_off, rx_pll_off,
			proto});
		check("read enable in reset", 8'h00, {7'h00, data_oe});
		resetn = 1'b1;
		rd_chk("topology after reset", 16'h0100, 8'h00);
		print_verdict();
	end
endmodule
